/* File: hw/fds_pkg.sv */
package fds_pkg;
  // Clock and divider geometry
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          FRAC_W        = 43;
  localparam int          INT_W         = 8;
  localparam int          DIVR_W        = INT_W + FRAC_W;
  localparam int          PHASE_W       = DIVR_W + 1;
  localparam int          NUM_FOD       = 4;
  localparam int          NUM_PATH      = 2;
  localparam logic [PHASE_W-1:0] ONE_CYCLE = 52'h0_0800_0000_0000;
  // Picoseconds to fraction units: 2^43 per clock period
  localparam logic [63:0] PS_TO_FRAC    = 64'((64'h1 << FRAC_W) / CLK_PERIOD_PS);
  // Per-period frequency offset for each phase-change rate
  localparam logic [63:0] STEP_FAST     = 64'h0000_0100_0000_0000;
  localparam logic [63:0] STEP_MEDIUM   = 64'h0000_0020_0000_0000;
  localparam logic [63:0] STEP_SLOW     = 64'h0000_0004_0000_0000;
  // Register word indices; fod index in addr[6:4]
  localparam logic [3:0]  REG_INT       = 4'h0;
  localparam logic [3:0]  REG_FRAC_LO   = 4'h1;
  localparam logic [3:0]  REG_FRAC_HI   = 4'h2;
  localparam logic [3:0]  REG_FINE      = 4'h3;
  localparam logic [3:0]  REG_RATE      = 4'h4;
  localparam logic [3:0]  REG_STATUS    = 4'h5;
  localparam logic [1:0]  PREG_DIV      = 2'h0;
  localparam logic [1:0]  PREG_HIGH     = 2'h1;
  localparam logic [1:0]  PREG_CTRL     = 2'h2;
  localparam logic        PATH_SEL_BIT  = 1'b1;
  // Reset values
  localparam logic [INT_W-1:0]  RST_INT  = 8'h14;
  localparam logic [FRAC_W-1:0] RST_FRAC = 43'h0;
  localparam logic [31:0]       RST_DIV  = 32'h0000_0002;
  localparam logic [31:0]       RST_HIGH = 32'h0000_0000;

  typedef enum logic [1:0] {
    FDS_RATE_SLOW,
    FDS_RATE_MEDIUM,
    FDS_RATE_FAST
  } fds_rate_t;

  // Offset magnitude for the selected rate
  function automatic logic [63:0] fds_step(input logic [1:0] rate);
    unique case (rate)
      2'h2:    fds_step = STEP_FAST;
      2'h1:    fds_step = STEP_MEDIUM;
      default: fds_step = STEP_SLOW;
    endcase
  endfunction : fds_step
endpackage : fds_pkg

/* File: hw/fds_path_if.sv */
`timescale 1ns/1ps
interface fds_path_if;
  logic        tick;
  logic [31:0] div;
  logic [31:0] high;
  logic        inv;
  logic        q;
  logic        nq;
  modport stage (input tick, input div, input high, input inv, output q, output nq);
  modport ctrl  (output tick, output div, output high, output inv, input q, input nq);
endinterface : fds_path_if

/* File: hw/fds_out_path.sv */
`timescale 1ns/1ps
module fds_out_path (
  input  wire logic   core_clk_i,
  input  wire logic   nrst_i,
  fds_path_if.stage   pth
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] div_s;
    logic [31:0] high_s;
    logic        q;
    logic        nq;
  } fds_path_state_t;

  fds_path_state_t state_reg;
  fds_path_state_t state_next;
  logic [31:0]     high_eff;
  logic            level;

  // Zero high count means even split, odd extra cycle goes low
  always_comb begin
    high_eff = (state_reg.high_s == 32'h0) ? (state_reg.div_s >> 1) : state_reg.high_s;
  end

  // Counter advances on divider ticks only; settings load at period end
  always_comb begin
    state_next = state_reg;
    level      = state_reg.q;
    if (pth.tick) begin
      if (state_reg.div_s < 32'h2) begin
        level           = ~state_reg.q; // Ratio one cannot pass a tick stream; fall back to half rate
        state_next.cnt  = 32'h0;
        state_next.div_s  = pth.div;
        state_next.high_s = pth.high;
      end else if (state_reg.cnt >= state_reg.div_s - 32'h1) begin
        state_next.cnt    = 32'h0;
        state_next.div_s  = pth.div;
        state_next.high_s = pth.high;
        level             = 1'b1; // Period start is always high-going
      end else begin
        state_next.cnt = state_reg.cnt + 32'h1;
        level          = (state_next.cnt < high_eff);
      end
    end
    state_next.q  = level;
    state_next.nq = pth.inv ? ~level : level;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '{cnt: 32'h0, div_s: fds_pkg::RST_DIV, high_s: fds_pkg::RST_HIGH, q: 1'b0, nq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pth.q  = state_reg.q;
  assign pth.nq = state_reg.nq;
endmodule : fds_out_path

/* File: hw/fds_top.sv */
`timescale 1ns/1ps
module fds_top (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  output logic      [31:0] rd_data_o,
  output logic      [3:0]  fod_tick_o,
  output logic      [3:0]  adj_busy_o,
  output logic      [7:0]  true_pin_o,
  output logic      [7:0]  comp_pin_o
);
  // Four dividers, each feeding one dual stage of two paths
  localparam int NF = fds_pkg::NUM_FOD;
  localparam int NP = fds_pkg::NUM_FOD * fds_pkg::NUM_PATH;

  // All divider, register and read state in one packed record, registered in a single process; path counters live in fds_out_path
  typedef struct packed {
    logic [NF-1:0][fds_pkg::INT_W-1:0]   int_part;
    logic [NF-1:0][fds_pkg::FRAC_W-1:0]  frac_part;
    logic [NF-1:0][1:0]                  rate;
    logic [NF-1:0][fds_pkg::PHASE_W-1:0] phase;
    logic [NF-1:0][63:0]                 remain;
    logic [NF-1:0]                       tick;
    logic [NF-1:0]                       busy;
    logic [NP-1:0][31:0]                 div;
    logic [NP-1:0][31:0]                 high;
    logic [NP-1:0]                       inv;
    logic [31:0]                         rd_data;
  } fds_state_t;

  // Current state and the value it takes at the next edge
  fds_state_t state_reg;
  fds_state_t state_next;
  logic [NF-1:0][fds_pkg::PHASE_W-1:0] div_eff;
  logic [NF-1:0][63:0]                 amt;
  logic [NF-1:0][fds_pkg::PHASE_W-1:0] sum;
  logic [2:0]                          fsel;
  logic [2:0]                          psel;
  logic [63:0]                         fine_frac;

  // One carrier per path; path p is served by divider p/2
  fds_path_if pif [NP] ();

  // Size of this period's offset: never overshoots what is left
  function automatic logic [63:0] fds_amount(input logic [63:0] rem, input logic [1:0] rate);
    logic [63:0] mag;
    logic [63:0] step;
    mag  = rem[63] ? (64'h0 - rem) : rem;
    step = fds_pkg::fds_step(rate);
    fds_amount = (mag > step) ? step : mag;
  endfunction : fds_amount

  // Divider words: four channels, low half of each sixteen-word block
  function automatic logic fds_fod_hit(input logic [7:0] a);
    fds_fod_hit = !a[7] && !a[3] && (a[6:4] < 3'(NF));
  endfunction : fds_fod_hit

  // Output path words: high half of each block below word 0x40
  function automatic logic fds_path_hit(input logic [7:0] a);
    fds_path_hit = !a[7] && a[3] && !a[6];
  endfunction : fds_path_hit

  // Channel and path select fields; the fine value is scaled to fraction units here
  // A 32-bit picosecond count times the scale stays within 64 bits, about one bit short of the limit, so the cut loses nothing
  always_comb begin
    fsel      = addr_i[6:4];
    psel      = {addr_i[5:4], addr_i[2]};
    fine_frac = 64'($signed(wr_data_i) * $signed({1'b0, fds_pkg::PS_TO_FRAC}));
  end

  // Accumulating divider per channel, one clock cycle is one input cycle
  // Ticks stand one cycle; the output paths and the feedback dividers share them
  // Channels never read each other's state, so their rates stay independent
  always_comb begin
    state_next = state_reg;
    for (int f = 0; f < NF; f++) begin
      amt[f]     = fds_amount(state_reg.remain[f], state_reg.rate[f]);
      div_eff[f] = {1'b0, state_reg.int_part[f], state_reg.frac_part[f]};
      // Positive remainder lengthens the period, delaying edges
      if (state_reg.remain[f][63]) begin
        div_eff[f] = div_eff[f] - amt[f][fds_pkg::PHASE_W-1:0];
      end else begin
        div_eff[f] = div_eff[f] + amt[f][fds_pkg::PHASE_W-1:0];
      end
      // A ratio below one would stall the comparison; clamp it
      if (div_eff[f] < fds_pkg::ONE_CYCLE) begin
        div_eff[f] = fds_pkg::ONE_CYCLE;
      end
      // Phase carries the residue from period to period, so the average ratio is exact
      sum[f]             = state_reg.phase[f] + fds_pkg::ONE_CYCLE;
      state_next.tick[f] = 1'b0;
      if (sum[f] >= div_eff[f]) begin
        state_next.phase[f] = sum[f] - div_eff[f];
        state_next.tick[f]  = 1'b1;
        // Offset used for this period is retired; nominal returns at zero
        state_next.remain[f] = state_reg.remain[f][63] ? state_reg.remain[f] + amt[f]
                                                       : state_reg.remain[f] - amt[f];
      end else begin
        state_next.phase[f] = sum[f];
      end
      // New steps add onto what is still pending
      if (wr_en_i && fds_fod_hit(addr_i) && fsel == 3'(f) && addr_i[3:0] == fds_pkg::REG_FINE) begin
        state_next.remain[f] = state_next.remain[f] + fine_frac;
      end
      // Busy is kept in a flop so the pin never shows the wide compare settling
      state_next.busy[f] = (state_next.remain[f] != 64'h0);
    end

    // Register writes; integer part and fraction apply on the next cycle
    // The two fraction halves land separately, so a ratio change spans two writes
    if (wr_en_i) begin
      if (fds_fod_hit(addr_i)) begin
        unique case (addr_i[3:0])
          fds_pkg::REG_INT:     state_next.int_part[fsel[1:0]] = wr_data_i[fds_pkg::INT_W-1:0];
          fds_pkg::REG_FRAC_LO: state_next.frac_part[fsel[1:0]][31:0] = wr_data_i;
          fds_pkg::REG_FRAC_HI: state_next.frac_part[fsel[1:0]][fds_pkg::FRAC_W-1:32] = wr_data_i[10:0];
          fds_pkg::REG_RATE:    state_next.rate[fsel[1:0]] = wr_data_i[1:0];
          default:              ;
        endcase
      end else if (fds_path_hit(addr_i)) begin
        unique case (addr_i[1:0])
          fds_pkg::PREG_DIV:  state_next.div[psel] = wr_data_i;
          fds_pkg::PREG_HIGH: state_next.high[psel] = wr_data_i;
          fds_pkg::PREG_CTRL: state_next.inv[psel] = wr_data_i[0];
          default:            ;
        endcase
      end
    end

    // Read data registered; unmapped words read zero
    // A read of the write-only fine word returns zero, not the last value written
    state_next.rd_data = 32'h0;
    if (rd_en_i) begin
      if (fds_fod_hit(addr_i)) begin
        unique case (addr_i[3:0])
          fds_pkg::REG_INT:     state_next.rd_data = 32'(state_reg.int_part[fsel[1:0]]);
          fds_pkg::REG_FRAC_LO: state_next.rd_data = state_reg.frac_part[fsel[1:0]][31:0];
          fds_pkg::REG_FRAC_HI: state_next.rd_data = 32'(state_reg.frac_part[fsel[1:0]][fds_pkg::FRAC_W-1:32]);
          fds_pkg::REG_RATE:    state_next.rd_data = 32'(state_reg.rate[fsel[1:0]]);
          // Status reads the registered busy flag, so software and the pin agree
          fds_pkg::REG_STATUS:  state_next.rd_data = {31'h0, state_reg.busy[fsel[1:0]]};
          default:              state_next.rd_data = 32'h0;
        endcase
      end else if (fds_path_hit(addr_i)) begin
        unique case (addr_i[1:0])
          fds_pkg::PREG_DIV:  state_next.rd_data = state_reg.div[psel];
          fds_pkg::PREG_HIGH: state_next.rd_data = state_reg.high[psel];
          fds_pkg::PREG_CTRL: state_next.rd_data = {31'h0, state_reg.inv[psel]};
          default:            state_next.rd_data = 32'h0;
        endcase
      end
    end
  end

  // Reset leaves a ratio of twenty, so ticks run from the first edge after release
  // Strobes are ignored while reset is held; writes made then are lost
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '{int_part:  {NF{fds_pkg::RST_INT}},
                     frac_part: {NF{fds_pkg::RST_FRAC}},
                     rate:      {NF{2'h0}},
                     phase:     '0,
                     remain:    '0,
                     tick:      '0,
                     busy:      '0,
                     div:       {NP{fds_pkg::RST_DIV}},
                     high:      {NP{fds_pkg::RST_HIGH}},
                     inv:       '0,
                     rd_data:   32'h0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Two paths per divider, both fed the same tick stream
  // The feedback dividers see the same tick on fod_tick_o, so both stay in step
  for (genvar p = 0; p < NP; p++) begin : g_path
    assign pif[p].tick = state_reg.tick[p / 2];
    assign pif[p].div  = state_reg.div[p];
    assign pif[p].high = state_reg.high[p];
    assign pif[p].inv  = state_reg.inv[p];
    fds_out_path u_path (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .pth        (pif[p])
    );
    assign true_pin_o[p] = pif[p].q;
    assign comp_pin_o[p] = pif[p].nq;
  end

  // Busy flags: a pending phase remainder per channel, taken straight from a flop
  assign adj_busy_o = state_reg.busy;

  // Ticks leave through a flop too; the feedback dividers count these pulses
  assign fod_tick_o = state_reg.tick;
  // Read data stands one cycle, then falls back to zero
  assign rd_data_o  = state_reg.rd_data;
endmodule : fds_top

/* File: tb/fds_top_chk.sv */
`timescale 1ns/1ps
module fds_top_chk (
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [3:0]  fod_tick_o,
  input wire logic [3:0]  adj_busy_o,
  input wire logic [7:0]  true_pin_o,
  input wire logic [7:0]  comp_pin_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Read data falls back to zero, so a stale word never passes for an answer
  rd_idle_a: assert property (!rd_en_i |=> rd_data_o == 32'h0)
    else $error("read data not idle");
  unmapped_rd_a: assert property (rd_en_i && addr_i[7] |=> rd_data_o == 32'h0)
    else $error("unmapped read not zero");
  status_rd_a: assert property (rd_en_i && addr_i == 8'h05 |=> rd_data_o == {31'h0, $past(adj_busy_o[0])})
    else $error("status does not follow busy");
  // True pins of a stage move only around a tick of their own divider
  route_zero_a: assert property ($changed(true_pin_o[1:0])
    |-> fod_tick_o[0] || $past(fod_tick_o[0]) || $past(fod_tick_o[0], 2))
    else $error("stage zero moved without its tick");
  route_one_a: assert property ($changed(true_pin_o[3:2])
    |-> fod_tick_o[1] || $past(fod_tick_o[1]) || $past(fod_tick_o[1], 2))
    else $error("stage one moved without its tick");
  route_two_a: assert property ($changed(true_pin_o[5:4])
    |-> fod_tick_o[2] || $past(fod_tick_o[2]) || $past(fod_tick_o[2], 2))
    else $error("stage two moved without its tick");
  route_three_a: assert property ($changed(true_pin_o[7:6])
    |-> fod_tick_o[3] || $past(fod_tick_o[3]) || $past(fod_tick_o[3], 2))
    else $error("stage three moved without its tick");
  // Adjust state starts only from a fine write and ends only at a tick
  busy_rise_a: assert property ($rose(adj_busy_o[0]) |-> $past(wr_en_i && addr_i == 8'h03))
    else $error("busy rose without write");
  busy_set_a: assert property (wr_en_i && addr_i == 8'h03 && !adj_busy_o[0] && wr_data_i[31:12] != 20'h0
    && wr_data_i[31:12] != 20'hfffff |=> adj_busy_o[0])
    else $error("fine write not pending");
  busy_fall_a: assert property ($fell(adj_busy_o[0])
    |-> fod_tick_o[0] || $past(fod_tick_o[0]) || $past(fod_tick_o[0], 2))
    else $error("busy fell without tick");
  busy_c: cover property ($rose(adj_busy_o[0]));
  pin_c: cover property ($rose(true_pin_o[1]));
  status_c: cover property (rd_en_i && addr_i == 8'h05 && adj_busy_o[0]);
endmodule : fds_top_chk
bind fds_top fds_top_chk u_chk (.core_clk_i, .nrst_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i,
  .rd_data_o, .fod_tick_o, .adj_busy_o, .true_pin_o, .comp_pin_o);

/* File: tb/fds_rx_model.sv */
`timescale 1ns/1ps
module fds_rx_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        tick_i,
  input  wire logic        pin_i,
  output logic      [15:0] gap_o,
  output logic      [15:0] per_o,
  output logic      [15:0] hi_o
);
  logic [15:0] t_reg, p_reg, h_reg;
  logic        q_reg;
  // Receiver side: counters restart on each tick or rising pin edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {t_reg, p_reg, h_reg, q_reg, gap_o, per_o, hi_o} <= 97'h0;
    end else begin
      t_reg <= tick_i ? 16'h1 : t_reg + 16'h1;
      if (tick_i) gap_o <= t_reg;
      q_reg <= pin_i;
      p_reg <= (pin_i && !q_reg) ? 16'h1 : p_reg + 16'h1;
      h_reg <= (pin_i && !q_reg) ? 16'h1 : h_reg + {15'h0, pin_i};
      if (pin_i && !q_reg) begin
        per_o <= p_reg;
        hi_o  <= h_reg;
      end
    end
  end
endmodule : fds_rx_model

/* File: tb/fds_top_bench.sv */
`timescale 1ns/1ps
module fds_top_bench;
  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic        wr_en_i    = 1'b0;
  logic        rd_en_i    = 1'b0;
  logic [7:0]  addr_i     = 8'h00;
  logic [31:0] wr_data_i  = 32'h0;
  logic [31:0] rd_data_o;
  logic [3:0]  fod_tick_o, adj_busy_o;
  logic [7:0]  true_pin_o, comp_pin_o;
  logic [15:0] gap0, per0, hi0, gap1, per1, hi1, per2, hi2;
  int          num_errors = 0;
  int          compares   = 0;
  int          cyc, n;
  fds_top dut_u (.core_clk_i, .nrst_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i, .rd_data_o,
    .fod_tick_o, .adj_busy_o, .true_pin_o, .comp_pin_o);
  fds_rx_model rx0 (.clk_i(core_clk_i), .nrst_i, .tick_i(fod_tick_o[0]), .pin_i(true_pin_o[0]),
    .gap_o(gap0), .per_o(per0), .hi_o(hi0));
  fds_rx_model rx1 (.clk_i(core_clk_i), .nrst_i, .tick_i(fod_tick_o[3]), .pin_i(true_pin_o[6]),
    .gap_o(gap1), .per_o(per1), .hi_o(hi1));
  fds_rx_model rx2 (.clk_i(core_clk_i), .nrst_i, .tick_i(fod_tick_o[0]), .pin_i(true_pin_o[1]),
    .gap_o(), .per_o(per2), .hi_o(hi2));
  // Core clock
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Strobes rise and fall at falling edges, so the rising edge sees them settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk_i);
    {wr_en_i, addr_i, wr_data_i} = {1'b1, a, d};
    @(negedge core_clk_i);
    wr_en_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge core_clk_i);
    {rd_en_i, addr_i} = {1'b1, a};
    @(negedge core_clk_i);
    rd_en_i = 1'b0;
    chk($sformatf("reg_%h", a), e, rd_data_o);
  endtask : rd
  // Waits for k ticks of divider zero, counting cycles; a hang ends the run
  task automatic tk(input int k);
    for (int i = 0; i < 2000 && k > 0; i++) begin
      @(negedge core_clk_i);
      cyc++;
      if (fod_tick_o[0] === 1'b1) k--;
    end
    if (k > 0) begin
      num_errors++;
      stop_test();
    end
  endtask : tk
  // Counts ticks until the pending adjust is retired; one tick of slack for alignment
  task automatic bt(input logic [31:0] e);
    n = 0;
    for (int i = 0; i < 20000 && adj_busy_o[0] !== 1'b0; i++) begin
      @(negedge core_clk_i);
      if (fod_tick_o[0] === 1'b1) n++;
    end
    if (adj_busy_o[0] !== 1'b0) begin
      num_errors++;
      stop_test();
    end else begin
      chk("adj_ticks", 32'h1, {31'h0, n + 1 >= e && n <= e + 1});
    end
  endtask : bt
  task automatic adj(input logic [31:0] ps);
    tk(1);
    wr(8'h03, ps);
    cyc = 2;
    tk(40);
  endtask : adj
  initial begin
    repeat (12) @(negedge core_clk_i);
    nrst_i = 1'b1;
    rd(8'h00, 32'h14);
    rd(8'h08, 32'h2);
    rd(8'h09, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h03, 32'h0);
    // Ratio 16.25 keeps clear of spur fractions
    wr(8'h00, 32'h10);
    wr(8'h02, 32'h200);
    wr(8'h30, 32'h15);
    wr(8'h08, 32'h4);
    wr(8'h0c, 32'hc);
    wr(8'h0d, 32'h4);
    wr(8'h0e, 32'h1);
    wr(8'h38, 32'h5);
    tk(40);
    rd(8'h0d, 32'h4);
    rd(8'h0e, 32'h1);
    rd(8'h02, 32'h200);
    chk("per0", 32'h41, {16'h0, per0});
    chk("hi0", 32'h1, {31'h0, hi0 == 16'h20 || hi0 == 16'h21});
    chk("per2", 32'hc3, {16'h0, per2});
    chk("hi2", 32'h41, {16'h0, hi2});
    chk("gap1", 32'h15, {16'h0, gap1});
    chk("per1", 32'h69, {16'h0, per1});
    chk("hi1", 32'h2a, {16'h0, hi1});
    chk("comp", {24'h0, true_pin_o ^ 8'h02}, {24'h0, comp_pin_o});
    for (int r = 0; r < 3; r++) begin
      wr(8'h04, 32'(r));
      wr(8'h03, 32'h1f40);
      rd(8'h05, 32'h1);
      bt(32'h400 >> (3 * r));
    end
    wr(8'h03, 32'h1f40);
    wr(8'h03, 32'h1f40);
    bt(32'h20);
    adj(32'h1f40);
    chk("late", 32'h1, {31'h0, cyc > 650});
    adj(32'hffffe0c0);
    chk("early", 32'h1, {31'h0, cyc < 650});
    rd(8'h05, 32'h0);
    // Divisor change mid-period lands at a boundary; the new period follows
    wr(8'h08, 32'h8);
    tk(40);
    chk("per0_new", 32'h82, {16'h0, per0});
    chk("hi0_new", 32'h41, {16'h0, hi0});
    stop_test();
  end
endmodule : fds_top_bench
